// *** include/udbs_pkg.sv ***
package udbs_pkg;

  // register offsets in the short i/o space
  localparam logic [7:0] UDBS_DATA_PORT_OFS = 8'h0c;
  localparam logic [7:0] UDBS_STATUS_A_OFS  = 8'h0b;
  // shift applied when the same registers are reached in data space
  localparam logic [7:0] UDBS_DATA_SPACE_OFS = 8'h20;

  // reset values
  localparam logic [7:0] UDBS_DATA_RESET   = 8'h00;
  localparam logic [7:0] UDBS_STATUS_RESET = 8'h20;

  // status register bit positions
  localparam int UDBS_RXC_BIT  = 7;
  localparam int UDBS_TXC_BIT  = 6;
  localparam int UDBS_UDRE_BIT = 5;
  localparam int UDBS_FE_BIT   = 4;
  localparam int UDBS_OVR_BIT  = 3;
  localparam int UDBS_PE_BIT   = 2;
  localparam int UDBS_U2X_BIT  = 1;
  localparam int UDBS_MPCM_BIT = 0;

  // samples per bit at normal and double speed
  localparam logic [4:0] UDBS_RATIO_NORMAL = 5'h10;
  localparam logic [4:0] UDBS_RATIO_DOUBLE = 5'h08;

  // character size codes
  localparam logic [2:0] UDBS_SIZE_5 = 3'h0;
  localparam logic [2:0] UDBS_SIZE_6 = 3'h1;
  localparam logic [2:0] UDBS_SIZE_7 = 3'h2;
  localparam logic [3:0] UDBS_BITS_MAX = 4'h8;

  // frame format handed to both shifters
  typedef struct packed {
    logic [3:0] nbits;
    logic       par_en;
    logic       par_odd;
  } udbs_fmt_t;

  // one receive buffer entry with its error flags
  typedef struct packed {
    logic [7:0] data;
    logic       fe;
    logic       ovr;
    logic       pe;
  } udbs_rx_entry_t;

  // data bits per character; other codes act as eight
  function automatic logic [3:0] udbs_char_bits(input logic [2:0] size);
    case (size)
      UDBS_SIZE_5: udbs_char_bits = 4'h5;
      UDBS_SIZE_6: udbs_char_bits = 4'h6;
      UDBS_SIZE_7: udbs_char_bits = 4'h7;
      default:     udbs_char_bits = UDBS_BITS_MAX;
    endcase
  endfunction : udbs_char_bits

  // mask of the used data bits
  function automatic logic [7:0] udbs_char_mask(input logic [3:0] nbits);
    udbs_char_mask = 8'hff >> (UDBS_BITS_MAX - nbits);
  endfunction : udbs_char_mask

  // parity bit for the used data bits
  function automatic logic udbs_parity(input logic [7:0] data, input udbs_fmt_t fmt);
    udbs_parity = (^(data & udbs_char_mask(fmt.nbits))) ^ fmt.par_odd;
  endfunction : udbs_parity

endpackage : udbs_pkg

// *** verilog/udbs_tx_shifter.sv ***
`timescale 1ns/10ps
`default_nettype none
module udbs_tx_shifter
  import udbs_pkg::*;
(
  input  wire logic       i_clk,   // system clock
  input  wire logic       i_rst_n, // async reset, active low
  input  wire logic       i_tick,  // sample tick
  input  wire logic [4:0] i_ratio, // samples per bit
  input  wire logic       i_load,  // take i_data, start frame
  input  wire logic [7:0] i_data,  // byte to send
  input  wire udbs_fmt_t  i_fmt,   // frame format
  output logic            o_txd,   // serial output, idle high
  output logic            o_busy,  // frame in progress
  output logic            o_done   // pulse: frame left the shifter
);
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} udbs_tx_state_t;

  udbs_tx_state_t state_reg;
  logic [4:0]     sub_reg;
  logic [3:0]     bit_reg;
  logic [7:0]     shift_reg;
  logic           par_reg;
  logic           bit_end;

  // a bit period ends after ratio ticks
  assign bit_end = i_tick & (sub_reg == 5'(i_ratio - 5'h01));
  assign o_busy  = (state_reg != TX_IDLE);

  // frame sequencer; only the used data bits go out
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= TX_IDLE;
      sub_reg   <= 5'h00;
      bit_reg   <= 4'h0;
      shift_reg <= 8'h00;
      par_reg   <= 1'b0;
      o_txd     <= 1'b1;
      o_done    <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_tick) begin
        sub_reg <= bit_end ? 5'h00 : 5'(sub_reg + 5'h01);
      end
      case (state_reg)
        TX_IDLE: begin
          o_txd <= 1'b1;
          if (i_load) begin
            shift_reg <= i_data & udbs_char_mask(i_fmt.nbits);
            par_reg   <= udbs_parity(i_data, i_fmt);
            sub_reg   <= 5'h00;
            bit_reg   <= 4'h0;
            o_txd     <= 1'b0;
            state_reg <= TX_START;
          end
        end
        TX_START: if (bit_end) begin
          o_txd     <= shift_reg[0];
          shift_reg <= shift_reg >> 1;
          state_reg <= TX_DATA;
        end
        TX_DATA: if (bit_end) begin
          bit_reg <= 4'(bit_reg + 4'h1);
          if (bit_reg == 4'(i_fmt.nbits - 4'h1)) begin
            o_txd     <= i_fmt.par_en ? par_reg : 1'b1;
            state_reg <= i_fmt.par_en ? TX_PAR : TX_STOP;
          end else begin
            o_txd     <= shift_reg[0];
            shift_reg <= shift_reg >> 1;
          end
        end
        TX_PAR: if (bit_end) begin
          o_txd     <= 1'b1;
          state_reg <= TX_STOP;
        end
        TX_STOP: if (bit_end) begin
          o_done    <= 1'b1;
          state_reg <= TX_IDLE;
        end
        default: state_reg <= TX_IDLE;
      endcase
    end
  end
endmodule : udbs_tx_shifter
`default_nettype wire

// *** verilog/udbs_rx_shifter.sv ***
`timescale 1ns/10ps
`default_nettype none
module udbs_rx_shifter
  import udbs_pkg::*;
(
  input  wire logic       i_clk,   // system clock
  input  wire logic       i_rst_n, // async reset, active low
  input  wire logic       i_en,    // receiver enabled
  input  wire logic       i_tick,  // sample tick
  input  wire logic [4:0] i_ratio, // samples per bit
  input  wire logic       i_rxd,   // synchronised line level
  input  wire udbs_fmt_t  i_fmt,   // frame format
  output logic            o_start, // pulse: start bit detected
  output logic            o_valid, // pulse: character complete
  output udbs_rx_entry_t  o_char   // character and its flags
);
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} udbs_rx_state_t;

  udbs_rx_state_t state_reg;
  logic [4:0]     sub_reg;
  logic [3:0]     bit_reg;
  logic [7:0]     data_reg;
  logic           par_bad_reg;
  logic           bit_end;
  logic           mid_start;

  // sample the start bit in its middle, later bits one period on
  assign bit_end   = i_tick & (sub_reg == 5'(i_ratio - 5'h01));
  assign mid_start = i_tick & (sub_reg == 5'((i_ratio >> 1) - 5'h01));

  // frame receiver
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg   <= RX_IDLE;
      sub_reg     <= 5'h00;
      bit_reg     <= 4'h0;
      data_reg    <= 8'h00;
      par_bad_reg <= 1'b0;
      o_start     <= 1'b0;
      o_valid     <= 1'b0;
      o_char      <= '0;
    end else begin
      o_start <= 1'b0;
      o_valid <= 1'b0;
      if (i_tick) begin
        sub_reg <= bit_end ? 5'h00 : 5'(sub_reg + 5'h01);
      end
      if (!i_en) begin
        state_reg <= RX_IDLE;
      end else begin
        case (state_reg)
          RX_IDLE: if (!i_rxd) begin
            o_start   <= 1'b1;
            sub_reg   <= 5'h00;
            state_reg <= RX_START;
          end
          RX_START: if (mid_start) begin
            sub_reg   <= 5'h00;
            bit_reg   <= 4'h0;
            data_reg  <= 8'h00; // unused high bits stay zero
            state_reg <= i_rxd ? RX_IDLE : RX_DATA;
          end
          RX_DATA: if (bit_end) begin
            data_reg[bit_reg[2:0]] <= i_rxd;
            bit_reg <= 4'(bit_reg + 4'h1);
            if (bit_reg == 4'(i_fmt.nbits - 4'h1)) begin
              state_reg <= i_fmt.par_en ? RX_PAR : RX_STOP;
            end
          end
          RX_PAR: if (bit_end) begin
            par_bad_reg <= i_rxd ^ udbs_parity(data_reg, i_fmt);
            state_reg   <= RX_STOP;
          end
          RX_STOP: if (bit_end) begin
            o_valid     <= 1'b1;
            o_char.data <= data_reg & udbs_char_mask(i_fmt.nbits);
            o_char.fe   <= ~i_rxd; // first stop bit low
            o_char.ovr  <= 1'b0;
            o_char.pe   <= i_fmt.par_en & par_bad_reg;
            par_bad_reg <= 1'b0;
            state_reg   <= RX_IDLE;
          end
          default: state_reg <= RX_IDLE;
        endcase
      end
    end
  end
endmodule : udbs_rx_shifter
`default_nettype wire

// *** verilog/udbs_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module udbs_top
  import udbs_pkg::*;
#(
  parameter int RX_DEPTH = 2,  // receive fifo entries
  parameter int DIV_W    = 12  // baud divisor width
) (
  input  wire logic             I_CLK_SYS,     // 200 MHz system clock
  input  wire logic             I_RST_N,       // async reset, active low
  input  wire logic [7:0]       I_ADDR,        // register address
  input  wire logic             I_IO_ACC,      // 1: short i/o address, 0: data space
  input  wire logic             I_WR_STB,      // write strobe, one cycle
  input  wire logic             I_RD_STB,      // read strobe, one cycle
  input  wire logic [7:0]       I_WDATA,       // write data
  output logic      [7:0]       O_RDATA,       // read data
  output logic                  O_RD_VALID,    // pulse: read data valid
  input  wire logic             I_RX_EN,       // receiver enable bit
  input  wire logic             I_TX_EN,       // transmitter enable
  input  wire logic             I_SYNC_MODE,   // 1: synchronous mode
  input  wire logic [2:0]       I_CHAR_SIZE,   // character size code
  input  wire logic [1:0]       I_PARITY_MODE, // parity mode, high bit enables
  input  wire logic [DIV_W-1:0] I_BAUD_DIV,    // baud divisor
  input  wire logic             I_TXC_ACK,     // pulse: tx complete serviced
  input  wire logic             I_RXD,         // serial input pin
  output logic                  O_TXD          // serial out pin
);
  localparam int PTR_W = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
  localparam int CNT_W = $clog2(RX_DEPTH + 1);
  localparam logic [CNT_W-1:0] FIFO_FULL = CNT_W'(RX_DEPTH);
  localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);

  // refuse depths the index arithmetic cannot serve
  generate
    if (RX_DEPTH < 2 || (RX_DEPTH & (RX_DEPTH - 1)) != 0) begin : g_bad_depth
      $error("RX_DEPTH must be a power of two, at least 2");
    end
    if (DIV_W < 1 || DIV_W > 16) begin : g_bad_div
      $error("DIV_W must lie between 1 and 16");
    end
  endgenerate

  // address match in either the i/o or data view
  function automatic logic addr_hit(input logic [7:0] addr,
                                    input logic io_acc,
                                    input logic [7:0] ofs);
    addr_hit = io_acc ? (addr == ofs) : (addr == 8'(ofs + UDBS_DATA_SPACE_OFS));
  endfunction : addr_hit

  // bus decode
  logic data_hit;
  logic stat_hit;
  logic data_wr;
  logic data_rd;
  logic stat_wr;
  logic stat_rd;

  // rx path
  logic           rxd_s1_reg;
  logic           rxd_s2_reg;
  logic           rxd_s3_reg;
  logic           rxd_level_reg;
  logic           rx_start;
  logic           rx_valid;
  udbs_rx_entry_t rx_char;
  udbs_rx_entry_t pend_reg;
  logic           pend_valid_reg;
  logic           ovr_seen_reg;
  udbs_rx_entry_t fifo_mem [RX_DEPTH];
  logic [PTR_W-1:0] head_reg;
  logic [PTR_W-1:0] tail;
  logic [CNT_W-1:0] count_reg;
  logic           fifo_full;
  logic           fifo_empty;
  logic           pop;
  logic           move;
  udbs_rx_entry_t head_entry;

  // tx path
  logic [7:0] tx_hold_reg;
  logic       tx_full_reg;
  logic       tx_load;
  logic       tx_busy;
  logic       tx_done;
  logic       txc_reg;
  logic       txc_clear;

  // status bits kept here
  logic u2x_reg;
  logic mpcm_reg;
  logic [7:0] status;

  // baud and format
  logic [DIV_W-1:0] baud_cnt_reg;
  logic             tick_reg;
  logic [4:0]       ratio;
  udbs_fmt_t        fmt;

  // one address, direction picks the buffer
  assign data_hit = addr_hit(I_ADDR, I_IO_ACC, UDBS_DATA_PORT_OFS);
  assign stat_hit = addr_hit(I_ADDR, I_IO_ACC, UDBS_STATUS_A_OFS);
  assign data_wr  = I_WR_STB & data_hit;
  assign data_rd  = I_RD_STB & data_hit;
  assign stat_wr  = I_WR_STB & stat_hit;
  assign stat_rd  = I_RD_STB & stat_hit;

  // frame format from the control inputs
  assign fmt.nbits   = udbs_char_bits(I_CHAR_SIZE);
  assign fmt.par_en  = I_PARITY_MODE[1];
  assign fmt.par_odd = I_PARITY_MODE[0];

  // double speed only in asynchronous mode
  assign ratio = (u2x_reg & ~I_SYNC_MODE) ? UDBS_RATIO_DOUBLE : UDBS_RATIO_NORMAL;

  // sample tick every divisor+1 clocks
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      baud_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end else begin
      tick_reg <= (baud_cnt_reg == '0);
      if (baud_cnt_reg == '0) begin
        baud_cnt_reg <= I_BAUD_DIV;
      end else begin
        baud_cnt_reg <= DIV_W'(baud_cnt_reg - 1'b1);
      end
    end
  end

  // pin synchroniser; level moves when stages two and three agree
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rxd_s1_reg    <= 1'b1;
      rxd_s2_reg    <= 1'b1;
      rxd_s3_reg    <= 1'b1;
      rxd_level_reg <= 1'b1;
    end else begin
      rxd_s1_reg <= I_RXD;
      rxd_s2_reg <= rxd_s1_reg;
      rxd_s3_reg <= rxd_s2_reg;
      if (rxd_s2_reg == rxd_s3_reg) begin
        rxd_level_reg <= rxd_s3_reg;
      end
    end
  end

  udbs_rx_shifter u_rx (
    .i_clk   (I_CLK_SYS),
    .i_rst_n (I_RST_N),
    .i_en    (I_RX_EN),
    .i_tick  (tick_reg),
    .i_ratio (ratio),
    .i_rxd   (rxd_level_reg),
    .i_fmt   (fmt),
    .o_start (rx_start),
    .o_valid (rx_valid),
    .o_char  (rx_char)
  );

  // fifo bookkeeping
  assign fifo_full  = (count_reg == FIFO_FULL);
  assign fifo_empty = (count_reg == '0);
  assign pop        = data_rd & ~fifo_empty; // reads advance unless the fifo is empty
  assign move       = pend_valid_reg & (~fifo_full | pop);
  assign tail       = PTR_W'(head_reg + count_reg);
  assign head_entry = fifo_empty ? '0 : fifo_mem[head_reg];

  // waiting character outside the full fifo
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pend_reg       <= '0;
      pend_valid_reg <= 1'b0;
    end else if (!I_RX_EN) begin
      pend_valid_reg <= 1'b0;
    end else if (rx_valid) begin
      pend_reg       <= rx_char;
      pend_reg.ovr   <= ovr_seen_reg;
      pend_valid_reg <= 1'b1;
    end else if (move) begin
      pend_valid_reg <= 1'b0;
    end
  end

  // start bit while full with a character waiting
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ovr_seen_reg <= 1'b0;
    end else if (!I_RX_EN) begin
      ovr_seen_reg <= 1'b0;
    end else if (rx_start & pend_valid_reg & ~move) begin
      ovr_seen_reg <= 1'b1;
    end else if (rx_valid) begin
      ovr_seen_reg <= 1'b0;
    end
  end

  // fifo storage, written at the tail
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      for (int i = 0; i < RX_DEPTH; i++) begin
        fifo_mem[i] <= '0;
      end
    end else if (move) begin
      fifo_mem[tail] <= pend_reg;
    end
  end

  // fifo pointers; disable flushes entries and flags
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      head_reg  <= '0;
      count_reg <= '0;
    end else if (!I_RX_EN) begin
      head_reg  <= '0;
      count_reg <= '0;
    end else begin
      if (pop) begin
        head_reg <= PTR_W'(head_reg + 1'b1);
      end
      case ({move, pop})
        2'b10:   count_reg <= CNT_W'(count_reg + CNT_ONE);
        2'b01:   count_reg <= CNT_W'(count_reg - CNT_ONE);
        default: count_reg <= count_reg;
      endcase
    end
  end

  // transmit holding buffer; writes while full are dropped
  assign tx_load = tx_full_reg & I_TX_EN & ~tx_busy;

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      tx_hold_reg <= UDBS_DATA_RESET;
      tx_full_reg <= 1'b0;
    end else if (data_wr & ~tx_full_reg) begin
      tx_hold_reg <= I_WDATA;
      tx_full_reg <= 1'b1;
    end else if (tx_load) begin
      tx_full_reg <= 1'b0;
    end
  end

  udbs_tx_shifter u_tx (
    .i_clk   (I_CLK_SYS),
    .i_rst_n (I_RST_N),
    .i_tick  (tick_reg),
    .i_ratio (ratio),
    .i_load  (tx_load),
    .i_data  (tx_hold_reg),
    .i_fmt   (fmt),
    .o_txd   (O_TXD),
    .o_busy  (tx_busy),
    .o_done  (tx_done)
  );

  // tx complete: set wins over clear
  assign txc_clear = I_TXC_ACK | (stat_wr & I_WDATA[UDBS_TXC_BIT]);

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      txc_reg <= UDBS_STATUS_RESET[UDBS_TXC_BIT];
    end else if (tx_done & ~tx_full_reg) begin
      txc_reg <= 1'b1;
    end else if (txc_clear) begin
      txc_reg <= 1'b0;
    end
  end

  // writable status bits; error positions are not stored
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      u2x_reg  <= UDBS_STATUS_RESET[UDBS_U2X_BIT];
      mpcm_reg <= UDBS_STATUS_RESET[UDBS_MPCM_BIT];
    end else if (stat_wr) begin
      u2x_reg  <= I_WDATA[UDBS_U2X_BIT];
      mpcm_reg <= I_WDATA[UDBS_MPCM_BIT];
    end
  end

  // status view; errors belong to the head character
  always_comb begin
    status                = 8'h00;
    status[UDBS_RXC_BIT]  = ~fifo_empty;
    status[UDBS_TXC_BIT]  = txc_reg;
    status[UDBS_UDRE_BIT] = ~tx_full_reg;
    status[UDBS_FE_BIT]   = head_entry.fe;
    status[UDBS_OVR_BIT]  = head_entry.ovr;
    status[UDBS_PE_BIT]   = head_entry.pe;
    status[UDBS_U2X_BIT]  = u2x_reg;
    status[UDBS_MPCM_BIT] = mpcm_reg;
  end

  // registered read port; reads of the data port see the rx side
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_RDATA    <= 8'h00;
      O_RD_VALID <= 1'b0;
    end else begin
      O_RD_VALID <= I_RD_STB;
      if (data_rd) begin
        O_RDATA <= head_entry.data;
      end else if (stat_rd) begin
        O_RDATA <= status;
      end else if (I_RD_STB) begin
        O_RDATA <= 8'h00;
      end
    end
  end

endmodule : udbs_top
`default_nettype wire

// *** bench/udbs_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
module udbs_props
  import udbs_pkg::*;
#(
  parameter int DIV_W = 12  // divisor width
) (
  input wire logic             I_CLK_SYS,     // clock
  input wire logic             I_RST_N,       // reset
  input wire logic [7:0]       I_ADDR,        // address
  input wire logic             I_IO_ACC,      // space
  input wire logic             I_WR_STB,      // write
  input wire logic             I_RD_STB,      // read
  input wire logic [7:0]       I_WDATA,       // wdata
  input wire logic [7:0]       O_RDATA,       // rdata
  input wire logic             O_RD_VALID,    // valid
  input wire logic             I_RX_EN,       // rx on
  input wire logic             I_TX_EN,       // tx on
  input wire logic             I_SYNC_MODE,   // sync
  input wire logic [2:0]       I_CHAR_SIZE,   // size
  input wire logic [1:0]       I_PARITY_MODE, // parity
  input wire logic [DIV_W-1:0] I_BAUD_DIV,    // divisor
  input wire logic             I_TXC_ACK,     // ack
  input wire logic             I_RXD,         // rx pin
  input wire logic             O_TXD          // tx pin
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);
  // decoded reads in either address space
  logic [7:0] sh;
  logic       dp_rd;
  logic       st_rd;
  assign sh    = I_IO_ACC ? 8'h00 : UDBS_DATA_SPACE_OFS;
  assign dp_rd = I_RD_STB && (I_ADDR == UDBS_DATA_PORT_OFS + sh);
  assign st_rd = I_RD_STB && (I_ADDR == UDBS_STATUS_A_OFS + sh);
  rd_answer_a: assert property (I_RD_STB |=> O_RD_VALID)
    else $error("read not answered");
  valid_cause_a: assert property (O_RD_VALID |-> $past(I_RD_STB))
    else $error("stray read valid");
  unmapped_zero_a: assert property (I_RD_STB && !dp_rd && !st_rd |=> O_RDATA == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!O_RD_VALID |-> $stable(O_RDATA))
    else $error("read data moved");
  short_five_a: assert property (dp_rd && I_CHAR_SIZE == UDBS_SIZE_5 |=> O_RDATA[7:5] == 3'h0)
    else $error("unused bits not zero");
  short_seven_a: assert property (dp_rd && I_CHAR_SIZE == UDBS_SIZE_7 |=> !O_RDATA[7])
    else $error("bit seven not zero");
  start_len_a: assert property ($fell(O_TXD) |-> !O_TXD [*8])
    else $error("start bit too short");
  bit_len_a: assert property ($changed(O_TXD) |=> $stable(O_TXD) [*7])
    else $error("bit period too short");
  rx_off_flags_a: assert property (st_rd && !I_RX_EN && !$past(I_RX_EN)
    && !$past(I_RX_EN, 2) |=> !O_RDATA[7] && O_RDATA[4:2] == 3'h0)
    else $error("flags after flush");
  // main scenarios
  cover property (dp_rd);
  cover property (st_rd ##1 O_RDATA[UDBS_OVR_BIT]);
  cover property ($fell(O_TXD));
endmodule : udbs_props
`default_nettype wire

// *** bench/udbs_peer.sv ***
`timescale 1ns/10ps
`default_nettype none
module udbs_peer (
  input  wire logic i_clk,  // system clock
  input  wire logic i_line, // design serial out
  output logic      o_line  // design serial in
);
  // idle line rests high
  initial o_line = 1'b1;
  // drive a level for clks cycles, just after an edge
  task automatic hold(input logic lvl, input int clks);
    @(posedge i_clk);
    #1 o_line = lvl;
    repeat (clks - 1) @(posedge i_clk);
  endtask : hold
  // one frame, lsb first, optional even parity, bad parity or stop on demand
  task automatic send(input logic [7:0] d, input int n, input logic pen, input logic pbad,
                      input logic stp, input int per);
    logic p;
    p = pbad;
    hold(1'b0, per);
    for (int i = 0; i < n; i++) begin
      hold(d[i], per);
      p = p ^ d[i];
    end
    if (pen) hold(p, per);
    hold(stp, per);
    hold(1'b1, 2 * per);
  endtask : send
  // capture n bits at mid bit; idle line yields ones
  task automatic recv(input int n, input int per, output logic [7:0] d);
    int t;
    d = 8'h00;
    t = 0;
    while (i_line !== 1'b0 && t < 4000) begin
      @(posedge i_clk);
      t++;
    end
    repeat (per / 2) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      repeat (per) @(posedge i_clk);
      d[i] = i_line;
    end
  endtask : recv
endmodule : udbs_peer
`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
  import udbs_pkg::*;
  logic       clk, rst_n, io, wr, rd, rx_en, tx_en, sync, ack, rxd, txd, rvalid; // pins
  logic [7:0] addr, wdata, rdata, q, rq; // bus values
  logic [2:0] size;                      // char size
  logic [1:0] pmode;                     // parity mode
  int         n_errors, check_count;     // counters
  udbs_top i_udbs_top (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_IO_ACC(io),
    .I_WR_STB(wr), .I_RD_STB(rd), .I_WDATA(wdata), .O_RDATA(rdata), .O_RD_VALID(rvalid),
    .I_RX_EN(rx_en), .I_TX_EN(tx_en), .I_SYNC_MODE(sync), .I_CHAR_SIZE(size),
    .I_PARITY_MODE(pmode), .I_BAUD_DIV(12'h000), .I_TXC_ACK(ack), .I_RXD(rxd), .O_TXD(txd));
  udbs_peer i_udbs_peer (.i_clk(clk), .i_line(txd), .o_line(rxd));
  // free-running clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // compare and count
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // one strobe cycle, read data taken a cycle later; never read-modify-write
  task automatic acc(input logic w, input logic [7:0] a, input logic i, input logic [7:0] d);
    @(posedge clk);
    #1 {wr, rd, addr, io, wdata} = {w, !w, a, i, d};
    @(posedge clk);
    #1 {wr, rd} = 2'b00;
    q = rdata;
  endtask : acc
  task automatic wrr(input logic [7:0] a, input logic i, input logic [7:0] d);
    acc(1'b1, a, i, d);
  endtask : wrr
  task automatic rdc(input logic [7:0] a, input logic i, input logic [7:0] m, input logic [7:0] e);
    acc(1'b0, a, i, 8'h00);
    check(q & m, e);
  endtask : rdc
  task automatic t_reset();
    rdc(8'h2b, 1'b0, 8'hff, UDBS_STATUS_RESET);
    rdc(8'h0b, 1'b1, 8'hff, UDBS_STATUS_RESET);
    rdc(8'h0c, 1'b1, 8'hff, UDBS_DATA_RESET);
    rdc(8'h55, 1'b1, 8'hff, 8'h00);
  endtask : t_reset
  // held byte waits for enable, third write while full is dropped
  task automatic t_tx();
    wrr(8'h2c, 1'b0, 8'ha5);
    repeat (40) @(posedge clk);
    check({7'h0, txd}, 8'h01);
    rdc(8'h0b, 1'b1, 8'h60, 8'h00);
    tx_en = 1'b1;
    fork
      begin
        i_udbs_peer.recv(8, 16, rq);
        check(rq, 8'ha5);
        i_udbs_peer.recv(8, 16, rq);
        check(rq, 8'h3c);
      end
      begin
        repeat (5) @(posedge clk);
        wrr(8'h0c, 1'b1, 8'h3c);
        wrr(8'h0c, 1'b1, 8'h00);
        rdc(8'h0b, 1'b1, 8'h20, 8'h00);
      end
    join
    i_udbs_peer.recv(8, 16, rq);
    check(rq, 8'hff);
    rdc(8'h0b, 1'b1, 8'h60, 8'h60);
    wrr(8'h0b, 1'b1, 8'h40);
    rdc(8'h0b, 1'b1, 8'h40, 8'h00);
  endtask : t_tx
  // five-bit characters both ways, service ack, double speed
  task automatic t_short();
    size = UDBS_SIZE_5;
    fork
      i_udbs_peer.recv(5, 16, rq);
      wrr(8'h0c, 1'b1, 8'hff);
    join
    check(rq, 8'h1f);
    repeat (40) @(posedge clk);
    rdc(8'h0b, 1'b1, 8'h40, 8'h40);
    ack = 1'b1;
    @(posedge clk);
    #1 ack = 1'b0;
    rdc(8'h0b, 1'b1, 8'h40, 8'h00);
    i_udbs_peer.send(8'hff, 5, 1'b0, 1'b0, 1'b1, 16);
    rdc(8'h0c, 1'b1, 8'hff, 8'h1f);
    wrr(8'h0b, 1'b1, 8'h03);
    rdc(8'h0b, 1'b1, 8'h03, 8'h03);
    fork
      i_udbs_peer.recv(5, 8, rq);
      wrr(8'h0c, 1'b1, 8'h0a);
    join
    check(rq, 8'h0a);
    wrr(8'h0b, 1'b1, 8'h00);
  endtask : t_short
  // four characters unread: parity error on second, overrun on fourth
  task automatic t_fifo();
    size = 3'h3;
    pmode = 2'h2;
    i_udbs_peer.send(8'h11, 8, 1'b1, 1'b0, 1'b1, 16);
    i_udbs_peer.send(8'h22, 8, 1'b1, 1'b1, 1'b1, 16);
    i_udbs_peer.send(8'h33, 8, 1'b1, 1'b0, 1'b1, 16);
    i_udbs_peer.send(8'h44, 8, 1'b1, 1'b0, 1'b1, 16);
    rdc(8'h0b, 1'b1, 8'h9c, 8'h80);
    rdc(8'h0c, 1'b1, 8'hff, 8'h11);
    rdc(8'h0b, 1'b1, 8'h9c, 8'h84);
    rdc(8'h0c, 1'b1, 8'hff, 8'h22);
    rdc(8'h0b, 1'b1, 8'h9c, 8'h88);
    rdc(8'h0c, 1'b1, 8'hff, 8'h44);
    rdc(8'h0b, 1'b1, 8'h9c, 8'h00);
  endtask : t_fifo
  // low stop bit, then flush by receiver disable
  task automatic t_fe();
    pmode = 2'h0;
    i_udbs_peer.send(8'h5a, 8, 1'b0, 1'b0, 1'b0, 16);
    rdc(8'h0b, 1'b1, 8'h90, 8'h90);
    rx_en = 1'b0;
    repeat (3) @(posedge clk);
    rdc(8'h0b, 1'b1, 8'h9c, 8'h00);
    rdc(8'h0c, 1'b1, 8'hff, 8'h00);
    rx_en = 1'b1;
  endtask : t_fe
  task automatic stop_test();
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  // main sequence
  initial begin
    {rst_n, io, wr, rd, rx_en, tx_en, sync, ack} = 8'h48;
    {addr, wdata, size, pmode} = {8'h00, 8'h00, 3'h3, 2'h0};
    n_errors = 0;
    check_count = 0;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    t_reset();
    t_tx();
    t_short();
    t_fifo();
    t_fe();
    stop_test();
  end
  // watchdog
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    stop_test();
  end
endmodule : tb
bind udbs_top udbs_props #(.DIV_W(DIV_W)) i_udbs_props (.I_CLK_SYS(I_CLK_SYS),
  .I_RST_N(I_RST_N), .I_ADDR(I_ADDR), .I_IO_ACC(I_IO_ACC), .I_WR_STB(I_WR_STB),
  .I_RD_STB(I_RD_STB), .I_WDATA(I_WDATA), .O_RDATA(O_RDATA), .O_RD_VALID(O_RD_VALID),
  .I_RX_EN(I_RX_EN), .I_TX_EN(I_TX_EN), .I_SYNC_MODE(I_SYNC_MODE), .I_CHAR_SIZE(I_CHAR_SIZE),
  .I_PARITY_MODE(I_PARITY_MODE), .I_BAUD_DIV(I_BAUD_DIV), .I_TXC_ACK(I_TXC_ACK),
  .I_RXD(I_RXD), .O_TXD(O_TXD));
`default_nettype wire
